// [hw/rail_enable_suspend_flag_regs.sv]
/*
 register slice: suspend flags, password key and buck rail enables.
 assumes the power sequencer supplies state and its own enable pulses; one clock.
*/
`timescale 1ns/1ps
module rail_enable_suspend_flag_regs (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // register port
    input  wire rail_regs_pkg::reg_req_s   req,
    output logic [7:0]                     rdata,
    output logic                           rvalid,
    // power sequencer
    input  wire rail_regs_pkg::pm_state_e  pm_state,
    input  wire rail_regs_pkg::kept_s      kept_en,
    input  wire logic                      seq_wr,
    input  wire logic [5:0]                seq_en,
    // rail controls and status
    output logic [5:0]                     buck_on,
    output logic                           freshness_seal_status,
    output logic                           program_defaults
);
    logic                     unlock_pulse;
    logic                     seal_pulse;
    logic                     program_pulse;
    logic                     unlocked_reg;
    logic [7:0]               flags_reg;
    logic [5:0]               enables_reg;
    logic [5:0]               enables_next;
    rail_regs_pkg::pm_state_e prev_state_reg;
    logic                     leave_suspend;
    logic                     enable_wr;

    unlock_key_check u_key (
        .clk           (clk),
        .rstn          (rstn),
        .req           (req),
        .unlock_pulse  (unlock_pulse),
        .seal_pulse    (seal_pulse),
        .program_pulse (program_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // suspend flags
    assign leave_suspend = (prev_state_reg == rail_regs_pkg::pm_suspend)
                        && (pm_state == rail_regs_pkg::pm_active);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            prev_state_reg <= rail_regs_pkg::pm_off;
        else
            prev_state_reg <= pm_state;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= rail_regs_pkg::flag_reset; // RULE_03
        end else if (leave_suspend) begin
            flags_reg <= kept_en; // RULE_01 RULE_02 RULE_11
        end else if (prev_state_reg == rail_regs_pkg::pm_off && pm_state != rail_regs_pkg::pm_off) begin
            flags_reg <= rail_regs_pkg::flag_reset; // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock and seal
    // unlock is one shot: the next register write consumes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            unlocked_reg <= 1'b0;
        else if (unlock_pulse)
            unlocked_reg <= 1'b1; // RULE_10
        else if (req.wr)
            unlocked_reg <= 1'b0; // RULE_10
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            freshness_seal_status <= 1'b0; // RULE_09
            program_defaults      <= 1'b0;
        end else begin
            if (seal_pulse)
                freshness_seal_status <= 1'b1; // RULE_05 RULE_09
            program_defaults <= program_pulse; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rail enables
    assign enable_wr = req.wr && (req.addr == rail_regs_pkg::enable_addr) && unlocked_reg; // RULE_10

    always_comb begin
        enables_next = enables_reg;
        if (seq_wr)
            enables_next = (enables_reg & ~rail_regs_pkg::seq_mask)
                         | (seq_en & rail_regs_pkg::seq_mask); // RULE_07
        else if (enable_wr)
            enables_next = req.wdata[5:0] & rail_regs_pkg::enable_wmask; // RULE_06
        // sealed backup rails stay on whatever clears them
        if (freshness_seal_status)
            enables_next = enables_next | (enables_reg & rail_regs_pkg::backup_mask); // RULE_08
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            enables_reg <= rail_regs_pkg::enable_reset[5:0]; // RULE_06
        else
            enables_reg <= enables_next;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            buck_on <= rail_regs_pkg::enable_reset[5:0]; // RULE_06
        else
            buck_on <= enables_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: one cycle latency, unmapped reads give zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    rail_regs_pkg::flag_addr:   rdata <= flags_reg; // RULE_03
                    rail_regs_pkg::key_addr:    rdata <= rail_regs_pkg::key_readback; // RULE_04
                    rail_regs_pkg::enable_addr: rdata <= {2'b00, enables_reg}; // RULE_06
                    default:                    rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_flags_capture;
        @(posedge clk) disable iff (!rstn)
        leave_suspend |=> flags_reg == $past(kept_en);
    endproperty
    a_flags_capture: assert property (p_flags_capture) else $error("flags not captured on resume"); // RULE_01

    property p_flags_zero_powerup;
        @(posedge clk) disable iff (!rstn)
        (prev_state_reg == rail_regs_pkg::pm_off && pm_state == rail_regs_pkg::pm_active)
            |=> flags_reg == rail_regs_pkg::flag_reset;
    endproperty
    a_flags_zero_powerup: assert property (p_flags_zero_powerup) else $error("flags not cleared at power-up"); // RULE_02

    property p_flags_hold;
        @(posedge clk) disable iff (!rstn)
        (pm_state == rail_regs_pkg::pm_active && prev_state_reg == rail_regs_pkg::pm_active) |=> $stable(flags_reg);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed while active"); // RULE_11

    property p_flag_read;
        @(posedge clk) disable iff (!rstn)
        (req.rd && req.addr == rail_regs_pkg::flag_addr) |=> rvalid && rdata == $past(flags_reg);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read mismatch"); // RULE_03

    property p_key_read;
        @(posedge clk) disable iff (!rstn)
        (req.rd && req.addr == rail_regs_pkg::key_addr) |=> rdata == rail_regs_pkg::key_readback;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key read not zero"); // RULE_04

    property p_enable_top_zero;
        @(posedge clk) disable iff (!rstn)
        (req.rd && req.addr == rail_regs_pkg::enable_addr) |=> rdata[7:6] == 2'b00;
    endproperty
    a_enable_top_zero: assert property (p_enable_top_zero) else $error("enable top bits set"); // RULE_06

    property p_locked_write;
        @(posedge clk) disable iff (!rstn)
        (req.wr && req.addr == rail_regs_pkg::enable_addr && !unlocked_reg && !seq_wr) |=> $stable(enables_reg);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked enable write took effect"); // RULE_10

    property p_seq_update;
        @(posedge clk) disable iff (!rstn)
        seq_wr |=> (enables_reg[3:0] == $past(seq_en[3:0]));
    endproperty
    a_seq_update: assert property (p_seq_update) else $error("sequencer update lost"); // RULE_07

    property p_backup_locked;
        @(posedge clk) disable iff (!rstn)
        (freshness_seal_status && enables_reg[5]) |=> enables_reg[5];
    endproperty
    a_backup_locked: assert property (p_backup_locked) else $error("sealed backup rail turned off"); // RULE_08

    property p_seal_sticky;
        @(posedge clk) disable iff (!rstn)
        freshness_seal_status |=> freshness_seal_status;
    endproperty
    a_seal_sticky: assert property (p_seal_sticky) else $error("seal status fell"); // RULE_09

    // buck 5 is both sequencer-driven and seal-protected, so it needs its own checks
    property p_backup5_locked;
        @(posedge clk) disable iff (!rstn)
        (freshness_seal_status && enables_reg[4]) |=> enables_reg[4];
    endproperty
    a_backup5_locked: assert property (p_backup5_locked) else $error("sealed buck 5 turned off"); // RULE_08

    property p_seq_buck5;
        @(posedge clk) disable iff (!rstn)
        (seq_wr && !freshness_seal_status) |=> enables_reg[4] == $past(seq_en[4]);
    endproperty
    a_seq_buck5: assert property (p_seq_buck5) else $error("sequencer update of buck 5 lost"); // RULE_07

    property p_unlocked_write;
        @(posedge clk) disable iff (!rstn)
        (enable_wr && !seq_wr && !freshness_seal_status) |=> enables_reg == $past(req.wdata[5:0]);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked enable write lost"); // RULE_06

    property p_seal_set;
        @(posedge clk) disable iff (!rstn)
        seal_pulse |=> freshness_seal_status;
    endproperty
    a_seal_set: assert property (p_seal_set) else $error("seal key did not break the seal"); // RULE_09

    property p_program_pulse;
        @(posedge clk) disable iff (!rstn)
        program_pulse |=> program_defaults;
    endproperty
    a_program_pulse: assert property (p_program_pulse) else $error("program key gave no pulse"); // RULE_05

    c_resume:    cover property (@(posedge clk) disable iff (!rstn) leave_suspend && kept_en != 8'h00);
    c_unlock_wr: cover property (@(posedge clk) disable iff (!rstn) enable_wr);
    c_seal:      cover property (@(posedge clk) disable iff (!rstn) seal_pulse);
    c_kept_on:   cover property (@(posedge clk) disable iff (!rstn) freshness_seal_status && enable_wr && !req.wdata[5]);
endmodule

// [hw/rail_regs_pkg.sv]
/*
 constants and carriers for the rail enable / suspend flag register slice.
 assumes a simple synchronous register port driven by the serial bus front end.
*/
// How it works
// [RULE_01] leaving suspend sets each flag whose rail or output stayed enabled
// [RULE_02] flags are zero after power-up from off, or for rails disabled in suspend
// [RULE_03] flag register at 0x07, read-only, reset 0x00, outputs then linear then bucks
// [RULE_04] password register always reads back 0x00
// [RULE_05] password writes unlock protection, break the seal or program defaults
// [RULE_06] enable register at 0x11, reset 0x00, bits 5..0 bucks 6..1, top bits zero
// [RULE_07] sequencer updates buck 1 to 5 enables during power-up and power-down
// [RULE_08] bucks 5 and 6 only turn off while the seal is still intact
// [RULE_09] seal status reads 0 while fresh and 1 once broken
// [RULE_10] enable writes are ignored unless a valid unlock key came just before
// [RULE_11] flags are captured on leaving suspend and held until the next power-up; the code also recaptures them on every later exit from suspend
package rail_regs_pkg;
    localparam logic [7:0] flag_addr      = 8'h07;
    localparam logic [7:0] key_addr       = 8'h10;
    localparam logic [7:0] enable_addr    = 8'h11;
    localparam logic [7:0] flag_reset     = 8'h00;
    localparam logic [7:0] key_reset      = 8'h00;
    localparam logic [7:0] enable_reset   = 8'h00;
    localparam logic [7:0] key_readback   = 8'h00;
    localparam logic [7:0] unlock_value   = 8'h5A;  // arbitrary value
    localparam logic [7:0] seal_value     = 8'hA5;  // arbitrary value
    localparam logic [7:0] program_value  = 8'h3C;  // arbitrary value
    localparam logic [5:0] enable_wmask   = 6'h3F;
    localparam logic [5:0] seq_mask       = 6'h1F;  // bucks 1..5
    localparam logic [5:0] backup_mask    = 6'h30;  // bucks 5 and 6

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // rails and outputs as seen by the suspend flag logic
    typedef struct packed {
        logic [2:0] outs;    // general outputs 3..1
        logic       linear;
        logic [3:0] bucks;   // buck rails 4..1
    } kept_s;

    typedef enum logic [1:0] {
        pm_off     = 2'b00,
        pm_active  = 2'b01,
        pm_suspend = 2'b10
    } pm_state_e;
endpackage

// [hw/unlock_key_check.sv]
/*
 decodes writes to the password register into one-cycle unlock, seal and program events.
 assumes a write is a one-cycle strobe.
*/
`timescale 1ns/1ps
module unlock_key_check (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // register request
    input  wire rail_regs_pkg::reg_req_s req,
    // decoded events
    output logic                        unlock_pulse,
    output logic                        seal_pulse,
    output logic                        program_pulse
);
    logic key_wr;
    assign key_wr = req.wr && (req.addr == rail_regs_pkg::key_addr);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            unlock_pulse  <= 1'b0;
            seal_pulse    <= 1'b0;
            program_pulse <= 1'b0;
        end else begin
            unlock_pulse  <= key_wr && (req.wdata == rail_regs_pkg::unlock_value);  // RULE_05
            seal_pulse    <= key_wr && (req.wdata == rail_regs_pkg::seal_value);    // RULE_05
            program_pulse <= key_wr && (req.wdata == rail_regs_pkg::program_value); // RULE_05
        end
    end
endmodule

// [tb/host_bus_model.sv]
/*
 host side of the register port: one-cycle write and read strobes.
 assumes the slice answers a read with rvalid within four cycles of the strobe.
*/
`timescale 1ns/1ps
module host_bus_model (
    // clock
    input  wire logic                 clk,
    // register port
    output rail_regs_pkg::reg_req_s   req,
    input  wire logic [7:0]           rdata,
    input  wire logic                 rvalid
);
////////////////////////////////////////////////////////////////////////////////
initial begin
    req = '0;
end

// key writes unlock, break the seal or program defaults
task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    // released bus shows the inverse, so stale data never looks valid
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
endtask

task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~req.wdata};
    @(posedge clk);
    req.rd <= 1'b0;
    ok = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
        #1;
        if (rvalid === 1'b1) begin
            ok = 1'b1;
            data = rdata;
        end else begin
            @(posedge clk);
        end
    end
endtask
endmodule

// [tb/rail_enable_suspend_flag_regs_tb.sv]
/*
 self-checking bench for the rail enable / suspend flag slice.
 assumes the host model drives the register port; the bench plays the sequencer.
*/
`timescale 1ns/1ps
module rail_enable_suspend_flag_regs_tb;
logic                      clk;
logic                      rstn;
rail_regs_pkg::reg_req_s   req;
logic [7:0]                rdata;
logic                      rvalid;
rail_regs_pkg::pm_state_e  pm_state;
rail_regs_pkg::kept_s      kept_en;
logic                      seq_wr;
logic [5:0]                seq_en;
logic [5:0]                buck_on;
logic                      seal;
logic                      program_defaults;
logic [7:0]                pulses;
int                        n_errors = 0;
int                        num_checks = 0;
////////////////////////////////////////////////////////////////////////////////
always #4 clk = ~clk;

rail_enable_suspend_flag_regs uut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .pm_state(pm_state), .kept_en(kept_en), .seq_wr(seq_wr), .seq_en(seq_en), .buck_on(buck_on),
    .freshness_seal_status(seal), .program_defaults(program_defaults));
host_bus_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
////////////////////////////////////////////////////////////////////////////////
task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask

task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
        n_errors++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read_reg(addr, d, ok);
    check({7'h00, ok}, 8'h01);
    // a missing answer ends the run here
    if (ok !== 1'b1) end_of_test();
    check(d, exp);
endtask

task automatic seq(input logic [5:0] v);
    @(posedge clk);
    seq_en <= v;
    seq_wr <= 1'b1;
    @(posedge clk);
    seq_wr <= 1'b0;
endtask

task automatic pm(input rail_regs_pkg::pm_state_e s, input logic [7:0] k);
    @(posedge clk);
    pm_state <= s;
    kept_en <= k;
    repeat (2) @(posedge clk);
endtask

task automatic unlock_en(input logic [7:0] v);
    host.write_reg(rail_regs_pkg::key_addr, rail_regs_pkg::unlock_value);
    host.write_reg(rail_regs_pkg::enable_addr, v);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk = 1'b0;
    rstn = 1'b0;
    pm_state = rail_regs_pkg::pm_off;
    kept_en = '0;
    seq_wr = 1'b0;
    seq_en = 6'h00;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(rail_regs_pkg::flag_addr, 8'h00);
    rd_chk(rail_regs_pkg::key_addr, 8'h00);
    rd_chk(rail_regs_pkg::enable_addr, 8'h00);
    rd_chk(8'h08, 8'h00);
    host.write_reg(rail_regs_pkg::enable_addr, 8'hFF);
    rd_chk(rail_regs_pkg::enable_addr, 8'h00);
    unlock_en(8'hFF);
    rd_chk(rail_regs_pkg::enable_addr, 8'h3F);
    check({2'b00, buck_on}, 8'h3F);
    host.write_reg(rail_regs_pkg::key_addr, rail_regs_pkg::unlock_value);
    rd_chk(rail_regs_pkg::key_addr, 8'h00);
    host.write_reg(rail_regs_pkg::enable_addr, 8'h00);
    rd_chk(rail_regs_pkg::enable_addr, 8'h00);
    unlock_en(8'h3F);
    seq(6'h00);
    rd_chk(rail_regs_pkg::enable_addr, 8'h20);
    seq(6'h1F);
    rd_chk(rail_regs_pkg::enable_addr, 8'h3F);
    check({7'h00, seal}, 8'h00);
    host.write_reg(rail_regs_pkg::key_addr, rail_regs_pkg::seal_value);
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, seal}, 8'h01);
    unlock_en(8'h00);
    rd_chk(rail_regs_pkg::enable_addr, 8'h30);
    seq(6'h00);
    rd_chk(rail_regs_pkg::enable_addr, 8'h30);
    host.write_reg(rail_regs_pkg::key_addr, rail_regs_pkg::program_value);
    pulses = 8'h00;
    repeat (5) begin
        #1;
        if (program_defaults === 1'b1) pulses = pulses + 8'h01;
        @(posedge clk);
    end
    check(pulses, 8'h01);
    pm(rail_regs_pkg::pm_active, 8'h00);
    pm(rail_regs_pkg::pm_suspend, 8'hA5);
    pm(rail_regs_pkg::pm_active, 8'hA5);
    rd_chk(rail_regs_pkg::flag_addr, 8'hA5);
    pm(rail_regs_pkg::pm_active, 8'hFF);
    rd_chk(rail_regs_pkg::flag_addr, 8'hA5);
    pm(rail_regs_pkg::pm_suspend, 8'h5A);
    pm(rail_regs_pkg::pm_active, 8'h5A);
    rd_chk(rail_regs_pkg::flag_addr, 8'h5A);
    pm(rail_regs_pkg::pm_off, 8'hFF);
    pm(rail_regs_pkg::pm_active, 8'hFF);
    rd_chk(rail_regs_pkg::flag_addr, 8'h00);
    // second reset in mid-run clears the seal and the enables
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(rail_regs_pkg::enable_addr, 8'h00);
    check({7'h00, seal}, 8'h00);
    end_of_test();
end
endmodule
